// ---- rtl/psc_regs.svh ----
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH
// register byte addresses
`define PSC_A_CTL     8'h6E
`define PSC_A_OFS     8'h6F
`define PSC_A_DATA    8'hA0
`define PSC_A_MIB     8'h74
`define PSC_A_MIB_END 8'h78
// control byte fields
`define PSC_TBL_MIB   3'h0
`define PSC_TBL_PS    3'h1
`define PSC_RD_BIT    4
`define PSC_MIB_SEL   2'h3
// counter word layout
`define PSC_OVF_BIT   38
`define PSC_VLD_BIT   37
`define PSC_CNT_W     30
// counter blocks by offset bits [7:5]
`define PSC_BLK_P1    3'h0
`define PSC_BLK_P2    3'h1
`define PSC_BLK_P3    3'h2
`define PSC_BLK_P4    3'h4
// frame length limits
`define PSC_L64   12'h040
`define PSC_L127  12'h07F
`define PSC_L255  12'h0FF
`define PSC_L511  12'h1FF
`define PSC_L1023 12'h3FF
`define PSC_L1522 12'h5F2
`define PSC_L1536 12'h600
`define PSC_L1916 12'h77C
`define PSC_L2000 12'h7D0
`define PSC_LMAX  12'h800
// counter offsets within a port block
`define PSC_RX_HP 5'h00
`define PSC_RX_SG 5'h01
`define PSC_RX_SB 5'h02
`define PSC_RX_LG 5'h03
`define PSC_RX_LB 5'h04
`define PSC_RX_SY 5'h05
`define PSC_RX_CK 5'h06
`define PSC_RX_FR 5'h07
`define PSC_RX_CT 5'h08
`define PSC_RX_FS 5'h09
`define PSC_RX_BC 5'h0A
`define PSC_RX_MC 5'h0B
`define PSC_RX_UC 5'h0C
`define PSC_RX_B0 5'h0D
`define PSC_TX_HP 5'h15
`define PSC_TX_LT 5'h16
`define PSC_TX_FS 5'h17
`define PSC_TX_BC 5'h18
`define PSC_TX_MC 5'h19
`define PSC_TX_UC 5'h1A
`define PSC_TX_PP 5'h1B
`define PSC_TX_AH 5'h1C
`define PSC_TX_AB 5'h1D
`define PSC_TX_OH 5'h1E
`define PSC_TX_MH 5'h1F
`endif

// ---- rtl/psc_pkg.sv ----
package psc_pkg;
   // one finished receive frame, valid for one cycle
   typedef struct packed {
      logic        vld;
      logic [11:0] len;
      logic        crc_ok;
      logic        sym_err;
      logic        frac;
      logic        pre_ok;
      logic        hi_prio;
      logic        bcast;
      logic        mcast;
      logic        ctl_type;
      logic        pause_da;
      logic        pause_op;
   } psc_rx_s;
   // one finished transmit attempt, valid for one cycle
   typedef struct packed {
      logic        vld;
      logic [11:0] len;
      logic        ok;
      logic        hi_prio;
      logic        pause;
      logic        bcast;
      logic        mcast;
      logic        late_col;
      logic        deferred;
      logic [3:0]  col_cnt;
      logic        excess;
   } psc_tx_s;
   typedef logic [11:0] psc_inc_t;
endpackage

// ---- rtl/psc_stat_top.sv ----
`timescale 1ns/1ps
`include "psc_regs.svh"
module psc_stat_top #(
   parameter logic [11:0] MAX_LEN = `PSC_LMAX
) (
   input  wire logic                       CORE_CLK_I,
   input  wire logic                       RST_B_I,
   input  wire logic [7:0]                 REG_ADDR_I,
   input  wire logic [7:0]                 REG_WDATA_I,
   input  wire logic                       REG_WR_I,
   input  wire logic                       REG_RD_I,
   input  wire logic                       MAX_1536_I,
   input  wire logic                       JABBER_LONG_I,
   input  wire psc_pkg::psc_rx_s [3:0]     RX_FRAME_I,
   input  wire psc_pkg::psc_tx_s [3:0]     TX_FRAME_I,
   output logic [7:0]                      REG_RDATA_O
);
   logic [7:0]   ctl_r;
   logic [7:0]   ofs_r;
   logic [7:0]   data_r;
   logic [39:0]  snap_r;
   logic [7:0]   ps_mem_r [4][64];
   logic [30:0]  pword [4];
   logic         ofs_wr;
   logic         data_wr;
   logic         mib_trig;
   logic         mib_hit;
   logic         ps_rd_hit;
   logic         ps_wr_hit;
   logic [1:0]   mib_port;
   logic         blk_ok;
   logic [1:0]   ps_port;
   logic         ps_ok;
   logic [7:0]   ps_rd_byte;

   // access strobes
   assign ofs_wr  = REG_WR_I && (REG_ADDR_I == `PSC_A_OFS);
   assign data_wr = REG_WR_I && (REG_ADDR_I == `PSC_A_DATA);
   assign mib_trig = ofs_wr && (ctl_r[7:5] == `PSC_TBL_MIB) && ctl_r[`PSC_RD_BIT]
                     && (ctl_r[3:2] == `PSC_MIB_SEL) && (ctl_r[1:0] == 2'h0);
   assign mib_hit  = mib_trig && blk_ok;
   // port field low bits pick the set; zero is the global set
   assign ps_port  = ctl_r[1:0];
   assign ps_ok    = (ctl_r[3:2] == 2'h0) && (ctl_r[7:5] == `PSC_TBL_PS);
   // offset write launches a table read
   assign ps_rd_hit = ofs_wr && ps_ok && ctl_r[`PSC_RD_BIT] && (REG_WDATA_I[7:6] == 2'h0);
   assign ps_wr_hit = data_wr && ps_ok && !ctl_r[`PSC_RD_BIT] && (ofs_r[7:6] == 2'h0);
   assign ps_rd_byte = ps_mem_r[ps_port][REG_WDATA_I[5:0]];

   // block decode, 0x60 block and above 0x9F unmapped
   always_comb begin
      mib_port = 2'h0;
      blk_ok   = 1'b1;
      case (REG_WDATA_I[7:5])
         `PSC_BLK_P1: mib_port = 2'h0;
         `PSC_BLK_P2: mib_port = 2'h1;
         `PSC_BLK_P3: mib_port = 2'h2;
         `PSC_BLK_P4: mib_port = 2'h3;
         default:     blk_ok   = 1'b0;
      endcase
   end

   // control and offset bytes
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ctl_r <= 8'h00;
         ofs_r <= 8'h00;
      end else begin
         if (REG_WR_I && (REG_ADDR_I == `PSC_A_CTL)) begin
            ctl_r <= REG_WDATA_I;
         end
         if (ofs_wr) begin
            ofs_r <= REG_WDATA_I;
         end
      end
   end

   // data byte: fetched on read trigger, or written by host
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         data_r <= 8'h00;
      end else if (ps_rd_hit) begin
         // fetched byte lands in the data register
         data_r <= ps_rd_byte;
      end else if (data_wr) begin
         data_r <= REG_WDATA_I;
      end
   end

   // power-saving table store; only four sets of 64 bytes kept
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         for (int s = 0; s < 4; s++) begin
            for (int b = 0; b < 64; b++) begin
               ps_mem_r[s][b] <= 8'h00;
            end
         end
      end else if (ps_wr_hit) begin
         // data byte write stores the entry
         ps_mem_r[ps_port][ofs_r[5:0]] <= REG_WDATA_I;
      end
   end

   // counter snapshot, taken in the same edge that clears the counter
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         snap_r <= 40'h00_0000_0000;
      end else if (mib_trig) begin
         snap_r <= 40'h00_0000_0000;
         if (blk_ok) begin
            // overflow and count placed, gap bits zero
            snap_r[`PSC_OVF_BIT]     <= pword[mib_port][30];
            snap_r[`PSC_CNT_W-1:0]   <= pword[mib_port][29:0];
            snap_r[`PSC_VLD_BIT]     <= 1'b1;
         end
      end
   end

   // register read port, answer one cycle after the strobe
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         REG_RDATA_O <= 8'h00;
      end else if (REG_RD_I) begin
         case (REG_ADDR_I)
            `PSC_A_CTL:  REG_RDATA_O <= ctl_r;
            `PSC_A_OFS:  REG_RDATA_O <= ofs_r;
            `PSC_A_DATA: REG_RDATA_O <= data_r;
            8'h74:       REG_RDATA_O <= snap_r[39:32];
            8'h75:       REG_RDATA_O <= snap_r[31:24];
            8'h76:       REG_RDATA_O <= snap_r[23:16];
            8'h77:       REG_RDATA_O <= snap_r[15:8];
            `PSC_A_MIB_END: REG_RDATA_O <= snap_r[7:0];
            default:     REG_RDATA_O <= 8'h00;
         endcase
      end
   end

   // per-port event classification and counter bank
   for (genvar p = 0; p < 4; p++) begin : g_port
      psc_pkg::psc_rx_s  rx;
      psc_pkg::psc_tx_s  tx;
      psc_pkg::psc_inc_t inc [32];
      logic [29:0]       cnt_r [32];
      logic              ovf_r [32];
      logic [11:0]       lmax;
      logic              rx_err;
      logic              in_rng;
      logic              rx_g;
      logic              tx_g;
      logic [30:0]       sum [32];

      assign rx     = RX_FRAME_I[p];
      assign tx     = TX_FRAME_I[p];
      assign lmax   = MAX_1536_I ? `PSC_L1536 : `PSC_L1522;
      assign rx_err = !rx.crc_ok || rx.sym_err || rx.frac;
      assign in_rng = (rx.len >= `PSC_L64) && (rx.len <= lmax);
      assign rx_g   = rx.vld && !rx_err;
      assign tx_g   = tx.vld && tx.ok;
      assign pword[p] = {ovf_r[REG_WDATA_I[4:0]], cnt_r[REG_WDATA_I[4:0]]};

      // increment per counter this cycle; octet counters add the length
      always_comb begin
         for (int i = 0; i < 32; i++) begin
            inc[i] = 12'h000;
         end
         inc[`PSC_RX_HP] = (rx.vld && rx.hi_prio) ? rx.len : 12'h000;
         inc[`PSC_RX_SG] = 12'(rx.vld && rx.crc_ok && (rx.len < `PSC_L64));
         inc[`PSC_RX_SB] = 12'(rx.vld && rx_err && (rx.len < `PSC_L64));
         // good frames over the size limit
         inc[`PSC_RX_LG] = 12'(rx.vld && rx.crc_ok && (rx.len > lmax));
         inc[`PSC_RX_LB] = 12'(rx.vld && (JABBER_LONG_I ? (rx.len > `PSC_L1916)
                                          : ((rx.len > `PSC_L1522) && rx_err)));
         inc[`PSC_RX_SY] = 12'(rx.vld && rx.sym_err && rx.pre_ok && in_rng);
         // checksum fail split by byte alignment
         inc[`PSC_RX_CK] = 12'(rx.vld && !rx.crc_ok && !rx.frac && in_rng);
         inc[`PSC_RX_FR] = 12'(rx.vld && !rx.crc_ok && rx.frac && in_rng);
         // control type, and fully qualified pause
         inc[`PSC_RX_CT] = 12'(rx.vld && rx.ctl_type);
         inc[`PSC_RX_FS] = 12'(rx.vld && rx.ctl_type && rx.pause_da && rx.pause_op
                               && (rx.len >= `PSC_L64) && rx.crc_ok);
         // good cast classes, control left out of multicast
         inc[`PSC_RX_BC] = 12'(rx_g && rx.bcast);
         inc[`PSC_RX_MC] = 12'(rx_g && rx.mcast && !rx.bcast && !rx.ctl_type);
         inc[`PSC_RX_UC] = 12'(rx_g && !rx.bcast && !rx.mcast);
         inc[`PSC_RX_B0]        = 12'(rx.vld && (rx.len == `PSC_L64));
         inc[`PSC_RX_B0 + 5'h1] = 12'(rx.vld && (rx.len > `PSC_L64) && (rx.len <= `PSC_L127));
         inc[`PSC_RX_B0 + 5'h2] = 12'(rx.vld && (rx.len > `PSC_L127) && (rx.len <= `PSC_L255));
         inc[`PSC_RX_B0 + 5'h3] = 12'(rx.vld && (rx.len > `PSC_L255) && (rx.len <= `PSC_L511));
         inc[`PSC_RX_B0 + 5'h4] = 12'(rx.vld && (rx.len > `PSC_L511) && (rx.len <= `PSC_L1023));
         inc[`PSC_RX_B0 + 5'h5] = 12'(rx.vld && (rx.len > `PSC_L1023) && (rx.len <= `PSC_L1522));
         inc[`PSC_RX_B0 + 5'h6] = 12'(rx.vld && (rx.len > `PSC_L1522) && (rx.len <= `PSC_L2000));
         inc[`PSC_RX_B0 + 5'h7] = 12'(rx.vld && (rx.len > `PSC_L2000) && (rx.len < MAX_LEN));
         // good high priority octets and late collisions
         inc[`PSC_TX_HP] = (tx_g && tx.hi_prio) ? tx.len : 12'h000;
         inc[`PSC_TX_LT] = 12'(tx.vld && tx.late_col);
         inc[`PSC_TX_FS] = 12'(tx_g && tx.pause);
         inc[`PSC_TX_BC] = 12'(tx_g && tx.bcast);
         inc[`PSC_TX_MC] = 12'(tx_g && tx.mcast && !tx.bcast);
         inc[`PSC_TX_UC] = 12'(tx_g && !tx.bcast && !tx.mcast);
         inc[`PSC_TX_PP] = 12'(tx.vld && tx.deferred);
         inc[`PSC_TX_AH] = tx.vld ? {8'h00, tx.col_cnt} : 12'h000;
         inc[`PSC_TX_AB] = 12'(tx.vld && tx.excess);
         inc[`PSC_TX_OH] = 12'(tx_g && (tx.col_cnt == 4'h1));
         inc[`PSC_TX_MH] = 12'(tx_g && (tx.col_cnt > 4'h1));
      end

      // carry out of bit 29 marks a wrap
      for (genvar i = 0; i < 32; i++) begin : g_sum
         assign sum[i] = {1'b0, cnt_r[i]} + {19'h0_0000, inc[i]};
      end

      // counters; an event in the clearing cycle is kept, not lost
      always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
         if (!RST_B_I) begin
            for (int i = 0; i < 32; i++) begin
               cnt_r[i] <= 30'h0000_0000;
               ovf_r[i] <= 1'b0;
            end
         end else begin
            for (int i = 0; i < 32; i++) begin
               if (mib_hit && (mib_port == p) && (REG_WDATA_I[4:0] == i)) begin
                  // cleared after the snapshot took it
                  cnt_r[i] <= {18'h0_0000, inc[i]};
                  ovf_r[i] <= 1'b0;
               end else begin
                  cnt_r[i] <= sum[i][29:0];
                  if (sum[i][30]) begin
                     ovf_r[i] <= 1'b1;
                  end
               end
            end
         end
      end
   end

   // read trigger fetches the selected entry
   a_ps_fetch: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      ps_rd_hit |=> (data_r == $past(ps_rd_byte)))
      else $error("table read did not fetch entry");

   // host sees the held data byte on every read of it
   a_data_read: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      (REG_RD_I && REG_ADDR_I == `PSC_A_DATA) |=> (REG_RDATA_O == $past(data_r)))
      else $error("data byte read mismatch");

   // written byte reaches global set entry 0x31
   a_ps_store: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      (ps_wr_hit && ps_port == 2'h0 && ofs_r[5:0] == 6'h31)
      |=> (ps_mem_r[0][49] == $past(REG_WDATA_I)))
      else $error("table write not stored");

   // reserved block returns an invalid word
   a_rsvd_block: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      (mib_trig && REG_WDATA_I[7:5] == 3'h3) |=> (snap_r == 40'h00_0000_0000))
      else $error("reserved block returned data");

   // gap and top bits of the word stay zero
   a_word_gap: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      (snap_r[36:30] == 7'h00) && !snap_r[39])
      else $error("reserved counter bits set");

   // valid flag still set two cycles after a mapped fetch
   a_valid_flag: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      mib_hit ##1 !mib_trig |=> snap_r[`PSC_VLD_BIT] [*1])
      else $error("valid flag missing after fetch");

   // port 1 first counter cleared to this cycle's increment
   a_read_clear: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      (mib_hit && mib_port == 2'h0 && REG_WDATA_I[4:0] == 5'h00)
      |=> (g_port[0].cnt_r[0] == {18'h0_0000, $past(g_port[0].inc[0])}))
      else $error("read did not clear counter");

   // high priority octets add the frame length
   a_hp_octets: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      (RX_FRAME_I[0].vld && RX_FRAME_I[0].hi_prio && !mib_trig && !g_port[0].sum[0][30])
      |=> (g_port[0].cnt_r[0] == 30'($past(g_port[0].cnt_r[0]) + $past(RX_FRAME_I[0].len))))
      else $error("octet count wrong");

   // a 64-byte frame bumps the smallest bin by one
   a_bin_64: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      (RX_FRAME_I[0].vld && RX_FRAME_I[0].len == `PSC_L64 && !mib_trig
       && !g_port[0].sum[13][30])
      |=> (g_port[0].cnt_r[13] == 30'($past(g_port[0].cnt_r[13]) + 30'h1)))
      else $error("size bin not counted");

   // wrap sets overflow and it holds without a read
   a_ovf_sticky: assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      (g_port[0].sum[22][30] && !mib_trig) ##1 !mib_trig |=> g_port[0].ovf_r[22])
      else $error("overflow flag lost");
endmodule

// ---- test/psc_stat_tb.sv ----
`timescale 1ns/1ps
module tb;
   localparam logic [11:0] MAX_LEN = 12'h800;
   localparam int          LIMIT   = 30000;
   logic                   core_clk;
   logic                   rst_b;
   logic [7:0]             reg_addr;
   logic [7:0]             reg_wdata;
   logic                   reg_wr;
   logic                   reg_rd;
   logic                   max_1536;
   logic                   jabber_long;
   psc_pkg::psc_rx_s [3:0] rx_frame;
   psc_pkg::psc_tx_s [3:0] tx_frame;
   logic [7:0]             reg_rdata;
   int                     bad_count = 0;
   int                     n_tests = 0;
   int                     cyc = 0;
   int unsigned            cnt [4][32];
   logic [7:0]             blk [4] = '{8'h00, 8'h20, 8'h40, 8'h80};
   int                     lens [20] = '{63, 64, 65, 127, 128, 255, 256, 511, 512, 1023,
                                         1024, 1522, 1523, 1536, 1537, 1916, 1917, 2000,
                                         2001, 2047};

   psc_stat_top #(.MAX_LEN(MAX_LEN)) dut (
      .CORE_CLK_I    (core_clk),
      .RST_B_I       (rst_b),
      .REG_ADDR_I    (reg_addr),
      .REG_WDATA_I   (reg_wdata),
      .REG_WR_I      (reg_wr),
      .REG_RD_I      (reg_rd),
      .MAX_1536_I    (max_1536),
      .JABBER_LONG_I (jabber_long),
      .RX_FRAME_I    (rx_frame),
      .TX_FRAME_I    (tx_frame),
      .REG_RDATA_O   (reg_rdata)
   );

   // 200 MHz core clock
   always #2.5 core_clk = ~core_clk;

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // hang guard, well above the expected run length
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         bad_count++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   // data is registered, so sample just after the read edge
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic fetch(input logic [7:0] ofs, output logic [39:0] w);
      logic [7:0] b;
      reg_write(8'h6E, 8'h1C);
      reg_write(8'h6F, ofs);
      for (int i = 0; i < 5; i++) begin
         reg_read(8'(8'h74 + i), b);
         w = {w[31:0], b};
      end
   endtask

   task automatic ctr_check(input int p, input int o);
      logic [39:0] w;
      fetch(8'(blk[p] + o), w);
      chk(w, {3'b001, 7'h00, cnt[p][o][29:0]});
      cnt[p][o] = 0;
   endtask

   function automatic psc_pkg::psc_rx_s gen_rx();
      psc_pkg::psc_rx_s f;
      int               k;
      f = '0;
      k = $urandom % 4;
      f.vld = $urandom % 2;
      f.len = 12'(lens[$urandom % 20]);
      f.crc_ok = (k == 0) || (k == 3);
      f.frac = (k == 2);
      f.sym_err = (k == 3);
      if (k == 3 && f.len < 12'h040) f.len = 12'h040;
      f.pre_ok = 1'b1;
      {f.hi_prio, f.bcast, f.mcast, f.ctl_type, f.pause_da, f.pause_op} = 6'($urandom);
      return f;
   endfunction

   function automatic psc_pkg::psc_tx_s gen_tx();
      psc_pkg::psc_tx_s f;
      f = '0;
      f.vld = $urandom % 2;
      f.len = 12'(lens[$urandom % 20]);
      {f.ok, f.hi_prio, f.pause, f.bcast, f.mcast, f.late_col, f.deferred} = 7'($urandom);
      f.col_cnt = 4'($urandom);
      f.excess = !f.ok && ($urandom % 2);
      return f;
   endfunction

   // every counter is modelled, so every counter is compared
   task automatic model_rx(input int p, input psc_pkg::psc_rx_s f);
      int l;
      int mx;
      int bn;
      bit bad;
      bit inr;
      l = f.len;
      mx = max_1536 ? 1536 : 1522;
      bad = !f.crc_ok || f.sym_err || f.frac;
      inr = (l >= 64) && (l <= mx);
      if (f.hi_prio) cnt[p][0] += l;
      if (l < 64) cnt[p][bad ? 2 : 1]++;
      if (f.crc_ok && l > mx) cnt[p][3]++;
      if (jabber_long ? l > 1916 : (l > 1522 && bad)) cnt[p][4]++;
      if (inr && f.sym_err) cnt[p][5]++;
      if (inr && !f.crc_ok) cnt[p][f.frac ? 7 : 6]++;
      if (f.ctl_type) cnt[p][8]++;
      if (f.ctl_type && f.pause_da && f.pause_op && l >= 64 && f.crc_ok) cnt[p][9]++;
      if (!bad) begin
         if (f.bcast) cnt[p][10]++;
         else if (f.mcast && !f.ctl_type) cnt[p][11]++;
         else if (!f.mcast) cnt[p][12]++;
      end
      bn = l == 64 ? 13 : l <= 127 ? 14 : l <= 255 ? 15 : l <= 511 ? 16 :
           l <= 1023 ? 17 : l <= 1522 ? 18 : l <= 2000 ? 19 : 20;
      if (l >= 64 && l < MAX_LEN) cnt[p][bn]++;
   endtask

   task automatic model_tx(input int p, input psc_pkg::psc_tx_s t);
      if (t.ok && t.hi_prio) cnt[p][21] += t.len;
      if (t.late_col) cnt[p][22]++;
      if (t.ok && t.pause) cnt[p][23]++;
      if (t.ok) cnt[p][t.bcast ? 24 : t.mcast ? 25 : 26]++;
      if (t.deferred) cnt[p][27]++;
      cnt[p][28] += t.col_cnt;
      if (t.excess) cnt[p][29]++;
      if (t.ok && t.col_cnt == 4'h1) cnt[p][30]++;
      if (t.ok && t.col_cnt > 4'h1) cnt[p][31]++;
   endtask

   task automatic traffic(input int n);
      psc_pkg::psc_rx_s r;
      psc_pkg::psc_tx_s t;
      repeat (n) begin
         @(posedge core_clk);
         for (int p = 0; p < 4; p++) begin
            r = gen_rx();
            t = gen_tx();
            rx_frame[p] <= r;
            tx_frame[p] <= t;
            if (r.vld) model_rx(p, r);
            if (t.vld) model_tx(p, t);
         end
      end
      @(posedge core_clk);
      rx_frame <= '0;
      tx_frame <= '0;
   endtask

   // power saving table access per set
   task automatic ps_test();
      logic [7:0] b;
      logic [7:0] v;
      for (int p = 0; p < 4; p++) begin
         v = 8'($urandom);
         reg_write(8'h6E, 8'(8'h20 | p));
         reg_write(8'h6F, 8'h31);
         reg_write(8'hA0, v);
         reg_write(8'h6E, 8'(8'h30 | p));
         reg_write(8'h6F, 8'h30);
         reg_read(8'hA0, b);
         chk(40'(b), 40'h0);
         reg_write(8'h6F, 8'h31);
         reg_read(8'hA0, b);
         chk(40'(b), 40'(v));
         reg_read(8'h6E, b);
         chk(40'(b), 40'(8'h30 | p));
      end
   endtask

   initial begin
      logic [7:0]  b;
      logic [39:0] w;
      core_clk = 1'b0;
      rst_b = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      max_1536 = 1'b0;
      jabber_long = 1'b0;
      rx_frame = '0;
      tx_frame = '0;
      cnt = '{default: 0};
      void'($urandom(32'h66C56AE2));
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      // snapshot is empty and not valid before any fetch
      for (int i = 0; i < 5; i++) begin
         reg_read(8'(8'h74 + i), b);
         chk(40'(b), 40'h0);
      end
      ps_test();
      // unmapped address and reserved counter block
      reg_read(8'h10, b);
      chk(40'(b), 40'h0);
      fetch(8'(8'h60 + ($urandom % 32)), w);
      chk(w, 40'h0);
      // every length setting combination
      for (int m = 0; m < 4; m++) begin
         @(posedge core_clk);
         max_1536    <= m[0];
         jabber_long <= m[1];
         traffic(150);
         for (int p = 0; p < 4; p++) begin
            for (int o = 0; o < 32; o++) ctr_check(p, o);
         end
      end
      // second pass must read back cleared counters
      for (int o = 0; o < 32; o++) ctr_check(3, o);
      // snapshot bytes ignore writes
      reg_write(8'h74, 8'hFF);
      reg_read(8'h74, b);
      chk(40'(b), 40'h20);
      tally_and_finish();
   end
endmodule
